// *** hdl/adc_conversion_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PWM_IRQ,
    input  wire logic [11:0] SAMPLE_DATA,
    output logic             ANALOG_POWER_ON,
    output logic             SAMPLE_HOLD,
    output logic             CONV_IRQ
);
    logic        start_bit_reg;
    logic        power_reg;
    logic        trig_sel_reg;
    logic        dly_en_reg;
    logic [7:0]  delay_reg;
    logic [11:0] result_reg;
    logic        irq_flag_reg;
    logic        irq_mask_reg;
    logic        global_en_reg;
    logic        conv_en_reg;
    conv_state_t state_reg;
    logic [4:0]  cyc_reg;
    logic        dly_run_reg;
    logic [7:0]  dly_cnt_reg;
    logic [31:0] prdata_reg;
    logic        wr;
    logic        rd;
    logic        start_fall;
    logic        dly_done;
    logic        launch;
    logic        conv_end;
    logic        busy;
    logic        ctrl0_wr;

    assign wr       = PSEL && PENABLE && PWRITE;
    assign rd       = PSEL && PENABLE && !PWRITE;
    assign ctrl0_wr = wr && (PADDR == ADDR_CTRL0);
    assign PREADY   = 1'b1;
    assign PSLVERR  = 1'b0;
    assign PRDATA   = prdata_reg;

    // The launch comes on the falling write of the start bit, not the rising one.
    assign start_fall = ctrl0_wr && start_bit_reg && !PWDATA[CTRL0_START_BIT]
                        && !trig_sel_reg;
    assign dly_done = dly_run_reg && (dly_cnt_reg == 8'h00);
    assign launch   = power_reg && (start_fall || dly_done);
    assign busy     = (state_reg != ST_IDLE);
    assign conv_end = (state_reg == ST_CONV) && (cyc_reg == TOTAL_CYCLES - 5'h01);

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            start_bit_reg <= 1'b0;
            power_reg     <= 1'b0;
        end
        else if (ctrl0_wr)
        begin
            start_bit_reg <= PWDATA[CTRL0_START_BIT];
            power_reg     <= PWDATA[CTRL0_POWER_BIT];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            trig_sel_reg  <= 1'b0;
            dly_en_reg    <= 1'b0;
            delay_reg     <= DELAY_RESET;
            irq_mask_reg  <= 1'b0;
            global_en_reg <= 1'b0;
            conv_en_reg   <= 1'b0;
        end
        else if (wr)
        begin
            case (PADDR)
                ADDR_CTRL2:
                begin
                    trig_sel_reg <= PWDATA[CTRL2_TRIG_BIT];
                    dly_en_reg   <= PWDATA[CTRL2_DLY_BIT];
                end
                ADDR_DELAY:    delay_reg    <= PWDATA[7:0];
                ADDR_IRQ_MASK: irq_mask_reg <= PWDATA[0];
                ADDR_IRQ_CFG:
                begin
                    global_en_reg <= PWDATA[IRQCFG_GLOBAL_BIT];
                    conv_en_reg   <= PWDATA[IRQCFG_CONV_BIT];
                end
                default: ;
            endcase
        end
    end

    // PWM-triggered start waits the programmed count before launching.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !power_reg)
        begin
            dly_run_reg <= 1'b0;
            dly_cnt_reg <= DELAY_RESET;
        end
        else if (PWM_IRQ && trig_sel_reg && dly_en_reg)
        begin
            dly_run_reg <= 1'b1;
            dly_cnt_reg <= delay_reg;
        end
        else if (dly_done)
            dly_run_reg <= 1'b0;
        else if (dly_run_reg)
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST || !power_reg)
        begin
            state_reg <= ST_IDLE;
            cyc_reg   <= 5'h00;
        end
        else if (launch)
        begin
            state_reg <= ST_SAMPLE;
            cyc_reg   <= 5'h00;
        end
        else
        begin
            case (state_reg)
                ST_IDLE: cyc_reg <= 5'h00;
                ST_SAMPLE:
                begin
                    cyc_reg <= cyc_reg + 5'h01;
                    if (cyc_reg == SAMPLE_CYCLES - 5'h01)
                        state_reg <= ST_CONV;
                end
                ST_CONV:
                begin
                    cyc_reg <= cyc_reg + 5'h01;
                    if (conv_end)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // The sample is latched at the end of the sample window and published at the end.
    logic [11:0] held_reg;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            held_reg   <= 12'h000;
            result_reg <= 12'h000;
        end
        else
        begin
            if (state_reg == ST_SAMPLE && cyc_reg == SAMPLE_CYCLES - 5'h01)
                held_reg <= SAMPLE_DATA & RESULT_FULL_SCALE;
            if (conv_end && !launch)
                result_reg <= held_reg;
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            irq_flag_reg <= 1'b0;
        else if (conv_end && !launch && power_reg)
            irq_flag_reg <= 1'b1;
        else if (wr && PADDR == ADDR_IRQ_STAT && PWDATA[0])
            irq_flag_reg <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            CONV_IRQ <= 1'b0;
        else
            CONV_IRQ <= irq_flag_reg && irq_mask_reg && global_en_reg && conv_en_reg;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            prdata_reg <= READ_ZERO;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            prdata_reg <= READ_ZERO;
            case (PADDR)
                ADDR_CTRL0:
                begin
                    prdata_reg[CTRL0_START_BIT] <= start_bit_reg;
                    prdata_reg[CTRL0_POWER_BIT] <= power_reg;
                    prdata_reg[CTRL0_BUSY_BIT]  <= busy;
                end
                ADDR_CTRL2:
                begin
                    prdata_reg[CTRL2_TRIG_BIT] <= trig_sel_reg;
                    prdata_reg[CTRL2_DLY_BIT]  <= dly_en_reg;
                end
                ADDR_DELAY:    prdata_reg[7:0] <= delay_reg;
                ADDR_RES_LOW:  prdata_reg[7:0] <= result_reg[7:0];
                ADDR_RES_HIGH: prdata_reg[3:0] <= result_reg[11:8];
                ADDR_IRQ_STAT: prdata_reg[0]   <= irq_flag_reg;
                ADDR_IRQ_MASK: prdata_reg[0]   <= irq_mask_reg;
                ADDR_IRQ_CFG:
                begin
                    prdata_reg[IRQCFG_GLOBAL_BIT] <= global_en_reg;
                    prdata_reg[IRQCFG_CONV_BIT]   <= conv_en_reg;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ANALOG_POWER_ON <= 1'b0;
            SAMPLE_HOLD     <= 1'b0;
        end
        else
        begin
            ANALOG_POWER_ON <= power_reg;
            SAMPLE_HOLD     <= power_reg && (state_reg == ST_SAMPLE);
        end
    end
endmodule : adc_conversion_sequencer
`default_nettype wire

// *** hdl/adc_seq_pkg.sv ***
package adc_seq_pkg;
    localparam logic [11:0] ADDR_CTRL0    = 12'h000;
    localparam logic [11:0] ADDR_CTRL2    = 12'h004;
    localparam logic [11:0] ADDR_DELAY    = 12'h008;
    localparam logic [11:0] ADDR_RES_LOW  = 12'h00c;
    localparam logic [11:0] ADDR_RES_HIGH = 12'h010;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
    localparam logic [11:0] ADDR_IRQ_CFG  = 12'h01c;
    // Control 0 fields.
    localparam int CTRL0_START_BIT = 0;
    localparam int CTRL0_POWER_BIT = 1;
    localparam int CTRL0_BUSY_BIT  = 2;
    // Control 2 fields.
    localparam int CTRL2_TRIG_BIT  = 0;
    localparam int CTRL2_DLY_BIT   = 1;
    // Interrupt config fields.
    localparam int IRQCFG_GLOBAL_BIT = 0;
    localparam int IRQCFG_CONV_BIT   = 1;
    localparam int RESULT_WIDTH      = 12;
    localparam logic [11:0] RESULT_FULL_SCALE = 12'hfff;
    localparam logic [4:0]  SAMPLE_CYCLES     = 5'h04;
    localparam logic [4:0]  CONVERT_CYCLES    = 5'h0c;
    localparam logic [4:0]  TOTAL_CYCLES      = 5'h10;
    localparam logic [7:0]  DELAY_RESET       = 8'h00;
    localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } conv_state_t;
endpackage : adc_seq_pkg

// *** tb/adc_seq_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker
    import adc_seq_pkg::*;
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        ANALOG_POWER_ON,
    input wire logic        SAMPLE_HOLD,
    input wire logic        CONV_IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);
    logic wr;
    assign wr = PSEL && PENABLE && PWRITE;
    ready_ok_a: assert property (PSEL |-> PREADY && !PSLVERR)
        else $error("slave stalled");
    unmapped_zero_a: assert property (PSEL && !PWRITE && PADDR == 12'h020
        |=> PRDATA == READ_ZERO) else $error("unmapped data");
    power_off_a: assert property (wr && PADDR == ADDR_CTRL0 && !PWDATA[1]
        |-> ##2 !ANALOG_POWER_ON) else $error("still powered");
    hold_power_a: assert property (SAMPLE_HOLD |-> ANALOG_POWER_ON)
        else $error("sampling unpowered");
    sample_len_a: assert property ($rose(SAMPLE_HOLD) |-> SAMPLE_HOLD [*4])
        else $error("short sampling");
    conv_len_a: assert property ($fell(SAMPLE_HOLD) && ANALOG_POWER_ON
        |-> (!$rose(CONV_IRQ)) [*8]) else $error("short conversion");
    irq_clear_a: assert property (wr && PADDR == ADDR_IRQ_STAT && PWDATA[0]
        |-> ##2 !CONV_IRQ) else $error("request kept");
    irq_mask_a: assert property (wr && PADDR == ADDR_IRQ_MASK && !PWDATA[0]
        |-> ##2 !CONV_IRQ) else $error("mask ignored");
endmodule : adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .ANALOG_POWER_ON(ANALOG_POWER_ON), .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_IRQ(CONV_IRQ));
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
    import adc_seq_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sel = 1'b0;
    logic        en = 1'b0;
    logic        wr = 1'b0;
    logic        pwm = 1'b0;
    logic        rdy;
    logic        pwr;
    logic        irq;
    logic [11:0] adr = 12'h000;
    logic [11:0] smp = 12'hfff;
    logic [31:0] wd = 32'h0;
    logic [31:0] prd;
    int          err_count = 0;
    int          samples_checked = 0;
    always #5 clk = ~clk;
    adc_conversion_sequencer dut (.CLK(clk), .SYS_RST(rst), .PSEL(sel), .PENABLE(en),
        .PWRITE(wr), .PADDR(adr), .PWDATA(wd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(),
        .PWM_IRQ(pwm), .SAMPLE_DATA(smp), .ANALOG_POWER_ON(pwr), .SAMPLE_HOLD(),
        .CONV_IRQ(irq));
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        err_count += int'(g !== e);
        if (g !== e)
            $display("wrong value at %0t: %h %h", $time, g, e);
    endtask : chk
    task results;
        $display("checks %0d wrong %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        sel <= 1'b1;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        en <= 1'b1;
        @(posedge clk);
        for (n = 0; rdy !== 1'b1 && n < 8; n++)
            @(posedge clk);
        sel <= 1'b0;
        en <= 1'b0;
        err_count += int'(n == 8);
        if (n == 8)
            results();
    endtask : bus
    task rchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(prd, e);
    endtask : rchk
    // Sampled just after the edge so the registered request has settled.
    task irq_at(input int k, input logic v);
        repeat (k) @(posedge clk);
        #1 chk({31'h0, irq}, {31'h0, v});
    endtask : irq_at
    task launch;
        bus(1'b1, ADDR_CTRL0, 32'h3);
        bus(1'b1, ADDR_CTRL0, 32'h2);
    endtask : launch
    task soft_conv;
        rchk(12'h020, READ_ZERO);
        bus(1'b1, ADDR_IRQ_CFG, 32'h3);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
        bus(1'b1, ADDR_CTRL0, 32'h2);
        launch();
        rchk(ADDR_CTRL0, 32'h6);
        // Request rises at the launch edge plus 17; the read above ends at plus 3.
        irq_at(13, 1'b0);
        irq_at(1, 1'b1);
        rchk(ADDR_CTRL0, 32'h2);
        rchk(ADDR_RES_LOW, 32'hff);
        rchk(ADDR_RES_HIGH, 32'hf);
        bus(1'b1, ADDR_IRQ_STAT, 32'h1);
        irq_at(1, 1'b0);
    endtask : soft_conv
    task restart_conv;
        launch();
        smp <= 12'h5a3;
        irq_at(10, 1'b0);
        launch();
        irq_at(16, 1'b0);
        irq_at(1, 1'b1);
        rchk(ADDR_RES_LOW, 32'ha3);
        bus(1'b1, ADDR_IRQ_MASK, 32'h0);
        irq_at(1, 1'b0);
        bus(1'b1, ADDR_IRQ_STAT, 32'h1);
        bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    endtask : restart_conv
    task pwm_cut;
        bus(1'b1, ADDR_CTRL2, 32'h3);
        bus(1'b1, ADDR_DELAY, 32'h5);
        pwm <= 1'b1;
        @(posedge clk);
        pwm <= 1'b0;
        irq_at(22, 1'b0);
        irq_at(1, 1'b1);
        bus(1'b1, ADDR_IRQ_STAT, 32'h1);
        bus(1'b1, ADDR_CTRL2, 32'h0);
        launch();
        irq_at(8, 1'b0);
        bus(1'b1, ADDR_CTRL0, 32'h0);
        irq_at(20, 1'b0);
        chk({31'h0, pwr}, 32'h0);
    endtask : pwm_cut
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        soft_conv();
        restart_conv();
        pwm_cut();
        results();
    end
endmodule : tb
`default_nettype wire
